// *** rtl/rbt_engine.v ***
// rectangle block transfer engine with axi4-lite registers and 128-bit memory ports
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "rbt_defs.vh"
module rbt_engine #(
  parameter DATA_W = 128, // memory word width
  parameter DIM_W  = 12   // width and height counter width
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              ce,         // low freezes all state
  input  wire [7:0]        s_awaddr,
  input  wire              s_awvalid,
  output reg               s_awready,
  input  wire [31:0]       s_wdata,
  input  wire [3:0]        s_wstrb,
  input  wire              s_wvalid,
  output reg               s_wready,
  output reg  [1:0]        s_bresp,
  output reg               s_bvalid,
  input  wire              s_bready,
  input  wire [7:0]        s_araddr,
  input  wire              s_arvalid,
  output reg               s_arready,
  output reg  [31:0]       s_rdata,
  output reg  [1:0]        s_rresp,
  output reg               s_rvalid,
  input  wire              s_rready,
  output reg               rd_req,     // memory read request
  output reg  [31:0]       rd_addr,
  output reg               rd_sys,     // 1 system memory, 0 frame buffer
  input  wire              rd_gnt,
  input  wire              rd_valid,
  input  wire [DATA_W-1:0] rd_data,
  output reg               wr_valid,   // memory write request
  output reg  [31:0]       wr_addr,
  output reg  [DATA_W-1:0] wr_data,
  output reg  [15:0]       wr_mask,    // byte enables
  output reg               wr_sys,
  input  wire              wr_ready,
  output reg               busy        // instruction buffer in progress
);
  localparam PW = 32 + DATA_W + 16 + 1; // write buffer payload
  // engine states
  localparam S_IDLE = 4'd0, S_IF = 4'd1, S_DEC = 4'd2, S_RS0 = 4'd3, S_RS1 = 4'd4;
  localparam S_RP = 4'd5, S_RD = 4'd6, S_PUSH = 4'd7, S_WDR = 4'd8;

  // software-visible registers
  reg [31:0] ibuf_q, spitch_q, dpitch_q, pat_q, fg_q, bg_q, clipx_q, clipy_q;
  reg [15:0] icount_q, donecnt_q;
  reg        tmode_q, go_q, err_q, done_q;
  reg [7:0]  awa_q;          // captured write address
  reg [31:0] wd_q;           // captured write data
  reg [3:0]  ws_q;
  reg        have_aw_q, have_w_q;
  // engine state
  reg [3:0]       st_q;
  reg [105:0]     ins_q;     // current instruction
  reg [DIM_W-1:0] ix_q, iy_q;
  reg [DATA_W-1:0] s0_q, s1_q, p_q, d_q;
  reg [31:0]      iaddr_q;
  reg [15:0]      icnt_q;
  reg             pend_q, bad_q;
  // two-entry write buffer: output stage and skid stage
  reg [PW-1:0]    sk_q;
  reg             sk_v_q;

  // merge a bus write into a register under its byte strobes
  function [31:0] wmerge(input [31:0] old, input [31:0] nw, input [3:0] st);
    integer k;
    begin
      wmerge = old;
      for (k = 0; k < 4; k = k + 1)
        if (st[k]) wmerge[8*k +: 8] = nw[8*k +: 8];
    end
  endfunction
  // merged count; the register keeps only the low half
  wire [31:0] icount_m = wmerge({16'h0000, icount_q}, wd_q, ws_q);

  // instruction decode
  wire [DIM_W-1:0] iw    = ins_q[`RBT_I_W];
  wire [DIM_W-1:0] ih    = ins_q[`RBT_I_H];
  wire [1:0]       kind  = ins_q[`RBT_I_KIND];
  wire [1:0]       sh    = ins_q[`RBT_I_DEPTH];   // log2 of bytes per pixel
  wire [31:0]      sa    = ins_q[`RBT_I_SRC];
  wire [31:0]      da    = ins_q[`RBT_I_DST];
  wire [7:0]       rop   = ins_q[`RBT_I_ROP];
  // copy backwards when destination lies after source in the same memory
  wire back = (kind == `RBT_K_MEM) && (ins_q[`RBT_I_SSYS] == ins_q[`RBT_I_DSYS]) && (da > sa);
  wire [DIM_W-1:0] wx  = back ? iw - 1'b1 - ix_q : ix_q;
  wire [DIM_W-1:0] ry  = back ? ih - 1'b1 - iy_q : iy_q;
  wire [DIM_W-1:0] sry = ins_q[`RBT_I_STR] ? (ry >> 1) : ry;           // stretch doubles rows
  wire [31:0] sw0 = {sa[31:4], 4'h0} + sry * spitch_q + {wx, 4'h0};
  wire [31:0] dwa = {da[31:4], 4'h0} + ry * dpitch_q + {wx, 4'h0};
  // pattern row repeats every 8 rows, 32 bpp rows span two words
  wire [3:0]  prow = (sh == 2'd2) ? {ry[2:0], wx[0]} : {1'b0, ry[2:0]};
  wire [31:0] pwa  = {pat_q[31:4], 4'h0} + {prow, 4'h0};
  // acceptance of the instruction
  wire sys_use = (ins_q[`RBT_I_SSYS] && kind == `RBT_K_MEM) || ins_q[`RBT_I_DSYS];
  wire ibad = (kind == 2'h3) || (sh == `RBT_D_BAD) || (iw == 0) || (ih == 0) ||
              (sys_use && !ins_q[`RBT_I_CACHE]);

  // source byte alignment from two adjacent words
  wire [2*DATA_W-1:0] s_pair = {s1_q, s0_q} >> {sa[3:0], 3'h0};
  wire [DATA_W-1:0] s_al = s_pair[DATA_W-1:0];
  // 8 bpp patterns hold one 64-bit row, repeated across the word
  wire [DATA_W-1:0] p_w = (sh == 2'd0) ? {p_q[63:0], p_q[63:0]} : p_q;
  wire [15:0] xbase = ({4'h0, wx} << 4) >> sh;  // first pixel column in word
  wire yin = ({4'h0, ry} >= clipy_q[15:0]) && ({4'h0, ry} <= clipy_q[31:16]);
  wire [1:0] lm = (sh == 2'd0) ? 2'd0 : (sh == 2'd1) ? 2'd1 : 2'd3;

  wire [DATA_W-1:0] exp_s, res;
  wire [15:0] beq, wm;
  genvar b;
  // per byte lane: colour expansion, clipping and transparency
  generate
    for (b = 0; b < 16; b = b + 1) begin : g_lane
      wire [31:0] bi  = b;
      wire [3:0]  bb  = bi[3:0];
      wire [3:0]  pix = bb >> sh;
      wire [1:0]  cl  = bb[1:0] & lm;
      wire [15:0] x   = xbase + {12'h0, pix};
      wire        bit1 = (kind == `RBT_K_SOLID) | s_al[pix];
      wire [31:0] col = bit1 ? fg_q : bg_q;
      wire [31:0] csh = col >> {cl, 3'h0};
      wire        peq;
      wire        in_c = yin && (x >= clipx_q[15:0]) && (x <= clipx_q[31:16]);
      // colour expansion for solid fills and monochrome sources
      assign exp_s[8*b +: 8] = (kind == `RBT_K_SOLID || ins_q[`RBT_I_MONO]) ?
                               csh[7:0] : s_al[8*b +: 8];
      assign beq[b] = d_q[8*b +: 8] == exp_s[8*b +: 8];
      // whole pixel matches only when all its bytes do
      assign peq = (sh == 2'd0) ? beq[b] :
                   (sh == 2'd1) ? &beq[(b/2)*2 +: 2] : &beq[(b/4)*4 +: 4];
      // opaque: clip only; transparent: write on difference or match
      assign wm[b] = in_c && (!ins_q[`RBT_I_TRANS] ||
                     (tmode_q ? peq : !peq));
    end
  endgenerate

  // raster operation: code bit indexed by pattern, source, destination
  genvar i;
  generate
    for (i = 0; i < DATA_W; i = i + 1) begin : g_rop
      assign res[i] = rop[{p_w[i], exp_s[i], d_q[i]}];
    end
  endgenerate

  // read address for each read state
  reg [31:0] ra;
  reg        rsys;
  always @* begin
    ra = iaddr_q;
    rsys = 1'b1;
    case (st_q)
      S_RS0: begin ra = sw0; rsys = ins_q[`RBT_I_SSYS]; end
      S_RS1: begin ra = sw0 + 32'h0000_0010; rsys = ins_q[`RBT_I_SSYS]; end
      S_RP:  begin ra = pwa; rsys = 1'b0; end
      S_RD:  begin ra = dwa; rsys = ins_q[`RBT_I_DSYS]; end
      default: begin ra = iaddr_q; rsys = 1'b1; end
    endcase
  end
  wire rd_st = (st_q == S_IF) || (st_q == S_RS0) || (st_q == S_RS1) ||
               (st_q == S_RP) || (st_q == S_RD);
  // every kind fetches the pattern word, so no raster operation sees a stale one
  wire [3:0] first = (kind == `RBT_K_MEM) ? S_RS0 : S_RP;
  wire push = (st_q == S_PUSH) && !sk_v_q;
  wire last_x = (ix_q == iw - 1'b1);
  wire last_y = (iy_q == ih - 1'b1);
  wire buf_empty = !wr_valid && !sk_v_q;
  wire fin = (st_q == S_WDR) && buf_empty;
  wire aw_go = have_aw_q && have_w_q && !s_bvalid;
  wire st_clr = aw_go && (awa_q == `RBT_STATUS);
  // status write-one-to-clear; a set in the same cycle wins
  wire set_err = (st_q == S_DEC) && ibad;
  wire set_done = fin && !bad_q;

  // axi4-lite slave and register file
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1; s_wready <= 1'b1; s_bvalid <= 1'b0; s_bresp <= `RBT_OKAY;
      s_arready <= 1'b1; s_rvalid <= 1'b0; s_rresp <= `RBT_OKAY; s_rdata <= `RBT_RST32;
      have_aw_q <= 1'b0; have_w_q <= 1'b0; awa_q <= 8'h00; wd_q <= `RBT_RST32; ws_q <= 4'h0;
      ibuf_q <= `RBT_RST32; icount_q <= 16'h0000; spitch_q <= `RBT_RST32;
      dpitch_q <= `RBT_RST32; pat_q <= `RBT_RST32; fg_q <= `RBT_RST32; bg_q <= `RBT_RST32;
      clipx_q <= `RBT_CLIP_RST; clipy_q <= `RBT_CLIP_RST;
      tmode_q <= 1'b0; go_q <= 1'b0; err_q <= 1'b0; done_q <= 1'b0;
    end else if (ce) begin
      go_q <= 1'b0;
      // address and data may arrive in either order
      if (s_awvalid && s_awready) begin
        awa_q <= s_awaddr; have_aw_q <= 1'b1; s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        wd_q <= s_wdata; ws_q <= s_wstrb; have_w_q <= 1'b1; s_wready <= 1'b0;
      end
      // both halves held: perform the write and answer
      if (aw_go) begin
        s_bvalid <= 1'b1;
        s_bresp <= `RBT_OKAY;
        case (awa_q)
          `RBT_CTRL: begin
            go_q <= ws_q[0] & wd_q[`RBT_CTRL_GO];
            if (ws_q[0]) tmode_q <= wd_q[`RBT_CTRL_TMODE];
          end
          `RBT_STATUS:  ;
          `RBT_IBUF:    ibuf_q   <= wmerge(ibuf_q, wd_q, ws_q);
          `RBT_ICOUNT:  icount_q <= icount_m[15:0];
          `RBT_SPITCH:  spitch_q <= wmerge(spitch_q, wd_q, ws_q);
          `RBT_DPITCH:  dpitch_q <= wmerge(dpitch_q, wd_q, ws_q);
          `RBT_PATADDR: pat_q    <= wmerge(pat_q, wd_q, ws_q);
          `RBT_FGCOL:   fg_q     <= wmerge(fg_q, wd_q, ws_q);
          `RBT_BGCOL:   bg_q     <= wmerge(bg_q, wd_q, ws_q);
          `RBT_CLIPX:   clipx_q  <= wmerge(clipx_q, wd_q, ws_q);
          `RBT_CLIPY:   clipy_q  <= wmerge(clipy_q, wd_q, ws_q);
          `RBT_DONECNT: ;
          default:      s_bresp  <= `RBT_SLVERR;   // unmapped
        endcase
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0; have_aw_q <= 1'b0; have_w_q <= 1'b0;
        s_awready <= 1'b1; s_wready <= 1'b1;
      end
      // sticky flags: hardware set beats software clear
      err_q  <= set_err  | (err_q  & ~(st_clr & ws_q[0] & wd_q[`RBT_ST_ERR]));
      done_q <= set_done | (done_q & ~(st_clr & ws_q[0] & wd_q[`RBT_ST_DONE]));
      // reads answer one cycle after the address is taken
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0; s_rvalid <= 1'b1; s_rresp <= `RBT_OKAY;
        case (s_araddr)
          `RBT_CTRL:    s_rdata <= {30'h0, tmode_q, 1'b0};
          `RBT_STATUS:  s_rdata <= {29'h0, done_q, err_q, busy};
          `RBT_IBUF:    s_rdata <= ibuf_q;
          `RBT_ICOUNT:  s_rdata <= {16'h0000, icount_q};
          `RBT_DONECNT: s_rdata <= {16'h0000, donecnt_q};
          `RBT_SPITCH:  s_rdata <= spitch_q;
          `RBT_DPITCH:  s_rdata <= dpitch_q;
          `RBT_PATADDR: s_rdata <= pat_q;
          `RBT_FGCOL:   s_rdata <= fg_q;
          `RBT_BGCOL:   s_rdata <= bg_q;
          `RBT_CLIPX:   s_rdata <= clipx_q;
          `RBT_CLIPY:   s_rdata <= clipy_q;
          default: begin s_rdata <= `RBT_RST32; s_rresp <= `RBT_SLVERR; end
        endcase
      end
      if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0; s_arready <= 1'b1;
      end
    end
  end

  // instruction sequencer and pixel word walk
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE; ins_q <= 106'h0; ix_q <= {DIM_W{1'b0}}; iy_q <= {DIM_W{1'b0}};
      s0_q <= {DATA_W{1'b0}}; s1_q <= {DATA_W{1'b0}}; p_q <= {DATA_W{1'b0}};
      d_q <= {DATA_W{1'b0}}; iaddr_q <= `RBT_RST32; icnt_q <= 16'h0000;
      pend_q <= 1'b0; bad_q <= 1'b0; rd_req <= 1'b0; rd_addr <= `RBT_RST32;
      rd_sys <= 1'b0; busy <= 1'b0; donecnt_q <= 16'h0000;
    end else if (ce) begin
      busy <= (st_q != S_IDLE) || go_q;
      // generic read: issue, wait for grant, wait for data
      if (rd_st && !rd_req && !pend_q) begin
        rd_req <= 1'b1; rd_addr <= ra; rd_sys <= rsys;
      end
      if (rd_req && rd_gnt) begin
        rd_req <= 1'b0; pend_q <= 1'b1;
      end
      case (st_q)
        S_IDLE: if (go_q && icount_q != 16'h0000) begin
          iaddr_q <= ibuf_q; icnt_q <= icount_q; st_q <= S_IF;
        end
        S_IF: if (pend_q && rd_valid) begin
          pend_q <= 1'b0; ins_q <= rd_data[105:0]; st_q <= S_DEC;
        end
        S_DEC: begin
          ix_q <= {DIM_W{1'b0}}; iy_q <= {DIM_W{1'b0}}; bad_q <= ibad;
          st_q <= ibad ? S_WDR : first;
        end
        S_RS0: if (pend_q && rd_valid) begin
          pend_q <= 1'b0; s0_q <= rd_data; st_q <= S_RS1;
        end
        S_RS1: if (pend_q && rd_valid) begin
          pend_q <= 1'b0; s1_q <= rd_data; st_q <= S_RP;
        end
        S_RP: if (pend_q && rd_valid) begin
          pend_q <= 1'b0; p_q <= rd_data; st_q <= S_RD;
        end
        S_RD: if (pend_q && rd_valid) begin
          pend_q <= 1'b0; d_q <= rd_data; st_q <= S_PUSH;
        end
        S_PUSH: if (push) begin
          // advance along the row, then to the next row
          if (last_x) begin
            ix_q <= {DIM_W{1'b0}};
            if (last_y) st_q <= S_WDR;
            else begin iy_q <= iy_q + 1'b1; st_q <= first; end
          end else begin
            ix_q <= ix_q + 1'b1; st_q <= first;
          end
        end
        // completion only once every write of the instruction has left
        S_WDR: if (buf_empty) begin
          if (!bad_q) donecnt_q <= donecnt_q + 1'b1;
          iaddr_q <= iaddr_q + 32'h0000_0010; icnt_q <= icnt_q - 1'b1;
          st_q <= (icnt_q == 16'h0001) ? S_IDLE : S_IF;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // two-entry write buffer; the skid stage absorbs one word of memory stall
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_valid <= 1'b0; wr_addr <= `RBT_RST32; wr_data <= {DATA_W{1'b0}};
      wr_mask <= 16'h0000; wr_sys <= 1'b0; sk_q <= {PW{1'b0}}; sk_v_q <= 1'b0;
    end else if (ce) begin
      if (!wr_valid || wr_ready) begin
        if (sk_v_q) begin
          {wr_addr, wr_data, wr_mask, wr_sys} <= sk_q;
          wr_valid <= 1'b1;
          sk_v_q <= 1'b0;
        end else begin
          {wr_addr, wr_data, wr_mask, wr_sys} <= {dwa, res, wm, ins_q[`RBT_I_DSYS]};
          wr_valid <= push;
        end
      end else if (push) begin
        sk_q <= {dwa, res, wm, ins_q[`RBT_I_DSYS]};
        sk_v_q <= 1'b1;
      end
    end
  end
endmodule // rbt_engine

// *** rtl/rbt_defs.vh ***
// offsets, fields, encodings and reset values of the rectangle transfer engine
`ifndef RBT_DEFS_VH
`define RBT_DEFS_VH
// register byte offsets on the axi4-lite port
`define RBT_CTRL     8'h00
`define RBT_STATUS   8'h04
`define RBT_IBUF     8'h08
`define RBT_ICOUNT   8'h0C
`define RBT_DONECNT  8'h10
`define RBT_SPITCH   8'h14
`define RBT_DPITCH   8'h18
`define RBT_PATADDR  8'h1C
`define RBT_FGCOL    8'h20
`define RBT_BGCOL    8'h24
`define RBT_CLIPX    8'h28
`define RBT_CLIPY    8'h2C
// control and status bits
`define RBT_CTRL_GO    0
`define RBT_CTRL_TMODE 1
`define RBT_ST_BUSY    0
`define RBT_ST_ERR     1
`define RBT_ST_DONE    2
// instruction word fields (one 128-bit word per instruction)
`define RBT_I_SRC    31:0
`define RBT_I_DST    63:32
`define RBT_I_W      75:64
`define RBT_I_H      87:76
`define RBT_I_ROP    95:88
`define RBT_I_KIND   97:96
`define RBT_I_TRANS  98
`define RBT_I_STR    99
`define RBT_I_MONO   100
`define RBT_I_DEPTH  102:101
`define RBT_I_SSYS   103
`define RBT_I_DSYS   104
`define RBT_I_CACHE  105
// source kinds and colour depths
`define RBT_K_MEM    2'h0
`define RBT_K_PAT    2'h1
`define RBT_K_SOLID  2'h2
`define RBT_D_BAD    2'h3
// axi answers and reset values
`define RBT_OKAY     2'h0
`define RBT_SLVERR   2'h2
`define RBT_RST32    32'h0000_0000
`define RBT_CLIP_RST 32'hFFFF_0000
`endif

// *** verif/rbt_engine_asserts.sv ***
// port checker for the rectangle transfer engine
`timescale 1ns/1ps
module rbt_engine_asserts #(
  parameter DATA_W = 128 // memory word width
) (
  input wire              aclk,
  input wire              aresetn,
  input wire              ce,
  input wire              s_awvalid,
  input wire              s_awready,
  input wire              s_wvalid,
  input wire              s_wready,
  input wire [1:0]        s_bresp,
  input wire              s_bvalid,
  input wire              s_bready,
  input wire [7:0]        s_araddr,
  input wire              s_arvalid,
  input wire              s_arready,
  input wire [31:0]       s_rdata,
  input wire [1:0]        s_rresp,
  input wire              s_rvalid,
  input wire              s_rready,
  input wire              rd_req,
  input wire [31:0]       rd_addr,
  input wire              rd_gnt,
  input wire              wr_valid,
  input wire [DATA_W-1:0] wr_data,
  input wire              wr_ready,
  input wire              busy
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // answers stand with their payload until taken
  bresp_hold_a: assert property (
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)) else $error("rdata dropped");
  // a waiting answer blocks new writes, so two writes never overlap
  bus_refuse_a: assert property (
    s_bvalid |-> !s_awready && !s_wready) else $error("write taken early");
  // the answer is launched one cycle after both halves are held
  wr_answer_a: assert property (
    ce && s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("no bvalid");
  rd_answer_a: assert property (
    ce && s_arvalid && s_arready |=> s_rvalid) else $error("no rvalid");
  // unmapped reads give zero with an error answer
  bad_read_a: assert property (
    ce && s_arvalid && s_arready && s_araddr > 8'h2C |=> s_rresp == 2'h2 && s_rdata == 32'h0000_0000)
    else $error("unmapped read");
  // memory requests hold until taken; reads are whole 128-bit words
  rd_hold_a: assert property (
    rd_req && !rd_gnt |=> rd_req && $stable(rd_addr)) else $error("read request moved");
  wr_hold_a: assert property (
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_data)) else $error("write request moved");
  rd_align_a: assert property (
    rd_req |-> rd_addr[3:0] == 4'h0) else $error("read not word aligned");
  // finishing means every write has left the buffer
  busy_end_a: assert property (
    $fell(busy) |-> !wr_valid) else $error("idle with writes pending");
endmodule // rbt_engine_asserts

bind rbt_engine rbt_engine_asserts #(.DATA_W(DATA_W)) rbt_engine_asserts_inst (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
  .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
  .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
  .rd_req(rd_req), .rd_addr(rd_addr), .rd_gnt(rd_gnt), .wr_valid(wr_valid),
  .wr_data(wr_data), .wr_ready(wr_ready), .busy(busy));

// *** verif/rbt_mem_model.sv ***
// behavioural frame buffer and system memory behind the engine
`timescale 1ns/1ps
module rbt_mem_model (
  input  wire         aclk,
  input  wire         stall,    // holds off all writes
  input  wire         rd_req,
  input  wire [31:0]  rd_addr,
  input  wire         rd_sys,
  output wire         rd_gnt,
  output reg          rd_valid = 1'h0,
  output reg  [127:0] rd_data = 128'h0,
  input  wire         wr_valid,
  input  wire [31:0]  wr_addr,
  input  wire [127:0] wr_data,
  input  wire [15:0]  wr_mask,
  input  wire         wr_sys,
  output wire         wr_ready
);
  reg [127:0] fb_mem [0:255];   // frame buffer words
  reg [127:0] sys_mem [0:255];  // system memory words, same start contents
  reg [3:0]   tick_q = 4'h0;    // free count, makes grants and answers slow at times
  reg         pend_q = 1'h0;    // one read outstanding
  reg [127:0] word_q;           // word waiting to return
  integer     i;
  // every 32-bit lane of every word differs from that lane of any other word
  initial begin
    for (i = 0; i < 256; i = i + 1) begin
      fb_mem[i] = {i[7:0], 24'h03_C35A, i[7:0], 24'h02_C35A, i[7:0], 24'h01_C35A, i[7:0], 24'h00_C35A};
      sys_mem[i] = fb_mem[i];
    end
  end
  assign rd_gnt   = rd_req && !pend_q && tick_q[1];
  assign wr_ready = !stall && tick_q[0];
  // reads answer a few cycles late; the data bus shows junk when idle
  always @(posedge aclk) begin
    tick_q <= tick_q + 4'h1;
    rd_valid <= 1'h0;
    rd_data <= ~rd_data;
    if (rd_gnt) begin
      pend_q <= 1'h1;
      word_q <= rd_sys ? sys_mem[rd_addr[11:4]] : fb_mem[rd_addr[11:4]];
    end else if (pend_q && tick_q[0]) begin
      pend_q <= 1'h0;
      rd_valid <= 1'h1;
      rd_data <= word_q;
    end
    // only enabled bytes change
    for (i = 0; i < 16; i = i + 1)
      if (wr_valid && wr_ready && wr_mask[i]) begin
        if (wr_sys) sys_mem[wr_addr[11:4]][8*i+:8] <= wr_data[8*i+:8];
        else fb_mem[wr_addr[11:4]][8*i+:8] <= wr_data[8*i+:8];
      end
  end
endmodule // rbt_mem_model

// *** verif/tb_top.sv ***
// self-checking bench for the rectangle transfer engine
`timescale 1ns/1ps
`include "rbt_defs.vh"
module tb_top;
  typedef struct packed {logic [7:0] rop; logic [1:0] kind; logic [4:0] f; logic [31:0] cx;} rbt_row_t;
  localparam [31:0] NC = `RBT_CLIP_RST; // no clipping
  // flags f: transparent, tmode, source in system memory, cacheable, error expected
  rbt_row_t rows [14] = '{'{8'hCC, 2'h0, 5'h00, NC}, '{8'h33, 2'h0, 5'h18, NC},
    '{8'h00, 2'h0, 5'h10, NC}, '{8'hFF, 2'h0, 5'h18, NC}, '{8'hFF, 2'h0, 5'h00, NC},
    '{8'h66, 2'h0, 5'h00, NC}, '{8'hF0, 2'h1, 5'h00, NC}, '{8'h5A, 2'h1, 5'h00, NC},
    '{8'hCC, 2'h0, 5'h00, 32'h0003_0001}, '{8'h88, 2'h0, 5'h00, 32'h0002_0000},
    '{8'hCC, 2'h0, 5'h06, NC}, '{8'h33, 2'h0, 5'h05, NC}, '{8'hCC, 2'h3, 5'h01, NC},
    '{8'h3C, 2'h0, 5'h00, NC}};
  reg          aclk, aresetn, ce, stall;
  reg  [7:0]   s_awaddr, s_araddr;
  reg  [31:0]  s_wdata, rv, c0;
  reg          s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  reg  [1:0]   rsp;
  wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid, busy;
  wire [1:0]   s_bresp, s_rresp;
  wire [31:0]  s_rdata, rd_addr, wr_addr;
  wire         rd_req, rd_sys, rd_gnt, rd_valid, wr_valid, wr_sys, wr_ready;
  wire [127:0] rd_data, wr_data;
  wire [15:0]  wr_mask;
  integer      err_count = 0, samples_checked = 0, cyc = 0, i;
  rbt_engine #(.DATA_W(128), .DIM_W(12)) rbt_engine_inst (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_sys(rd_sys), .rd_gnt(rd_gnt), .rd_valid(rd_valid), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_mask(wr_mask),
    .wr_sys(wr_sys), .wr_ready(wr_ready), .busy(busy));
  rbt_mem_model rbt_mem_model_inst (.aclk(aclk), .stall(stall), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_sys(rd_sys), .rd_gnt(rd_gnt), .rd_valid(rd_valid),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_mask(wr_mask), .wr_sys(wr_sys), .wr_ready(wr_ready));
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  // a hang ends the run as a failure
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      err_count = err_count + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk32(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t reg got %h want %h", $time, g, e);
      end
    end
  endtask
  task chk128(input [127:0] g, input [127:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t mem got %h want %h", $time, g, e);
      end
    end
  endtask
  // axi4-lite write: both halves offered, each released once taken
  task axi_wr(input [7:0] a, input [31:0] d);
    begin
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      rsp = 2'h1;
      while (rsp === 2'h1) begin
        @(posedge aclk);
        if (s_awvalid && s_awready) s_awvalid <= 1'h0;
        if (s_wvalid && s_wready) s_wvalid <= 1'h0;
        if (s_bvalid && s_bready) begin
          rsp = s_bresp;
          s_bready <= 1'h0;
        end
      end
      @(posedge aclk);
    end
  endtask
  task axi_rd(input [7:0] a, output [31:0] d);
    begin
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      rsp = 2'h1;
      while (rsp === 2'h1) begin
        @(posedge aclk);
        if (s_arvalid && s_arready) s_arvalid <= 1'h0;
        if (s_rvalid && s_rready) begin
          rsp = s_rresp;
          d = s_rdata;
          s_rready <= 1'h0;
        end
      end
      @(posedge aclk);
    end
  endtask
  // one 1x1 word instruction at 32 bits per pixel, source 0x400, destination 0x600
  function [127:0] mk(input rbt_row_t r);
    begin
      mk = {22'h0, r.f[1], 1'h0, r.f[2], 2'h2, 2'h0, r.f[4], r.kind, r.rop, 24'h001_001,
            32'h0000_0600, 32'h0000_0400};
    end
  endfunction
  // result from the 8-bit truth table, then per-pixel clip and transparency
  function [127:0] expect_word(input rbt_row_t r, input [127:0] s, p, d);
    integer b;
    begin
      for (b = 0; b < 128; b = b + 1) expect_word[b] = r.rop[{p[b], s[b], d[b]}];
      for (b = 0; b < 4; b = b + 1)
        if (r.f[0] || b < r.cx[15:0] || b > r.cx[31:16] ||
            (r.f[4] && ((s[32*b+:32] == d[32*b+:32]) != r.f[3])))
          expect_word[32*b+:32] = d[32*b+:32];
    end
  endfunction
  task go(input [31:0] n, input tm);
    begin
      axi_wr(`RBT_ICOUNT, n);
      axi_wr(`RBT_CTRL, {30'h0, tm, 1'h1});
    end
  endtask
  task run_row(input rbt_row_t r);
    reg [127:0] e;
    begin
      e = expect_word(r, r.f[2] ? rbt_mem_model_inst.sys_mem[64] : rbt_mem_model_inst.fb_mem[64],
                      rbt_mem_model_inst.fb_mem[80], rbt_mem_model_inst.fb_mem[96]);
      rbt_mem_model_inst.fb_mem[0] = mk(r);
      rbt_mem_model_inst.sys_mem[0] = mk(r);
      axi_rd(`RBT_DONECNT, c0);
      axi_wr(`RBT_CLIPX, r.cx);
      go(32'h1, r.f[3]);
      while (busy !== 1'h0) @(posedge aclk);
      axi_rd(`RBT_STATUS, rv);
      chk32({31'h0, rv[`RBT_ST_ERR]}, {31'h0, r.f[0]});
      axi_wr(`RBT_STATUS, 32'h0000_0006);
      axi_rd(`RBT_DONECNT, rv);
      chk32(rv, c0 + {31'h0, !r.f[0]});
      chk128(rbt_mem_model_inst.fb_mem[96], e);
    end
  endtask
  initial begin
    {aresetn, stall, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 7'h00;
    {ce, s_awaddr, s_araddr, s_wdata} = 49'h1_0000_0000_0000;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    // reset values and an unmapped place
    axi_rd(`RBT_CLIPX, rv);
    chk32(rv, `RBT_CLIP_RST);
    axi_rd(`RBT_DONECNT, rv);
    chk32(rv, `RBT_RST32);
    axi_rd(8'h40, rv);
    chk32(rv, `RBT_RST32);
    chk32({30'h0, rsp}, {30'h0, `RBT_SLVERR});
    axi_wr(8'h44, 32'h1234_5678);
    chk32({30'h0, rsp}, {30'h0, `RBT_SLVERR});
    $display("reset test done");
    axi_wr(`RBT_IBUF, 32'h0000_0000);
    axi_wr(`RBT_PATADDR, 32'h0000_0500);
    for (i = 0; i < 14; i = i + 1) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    for (i = 0; i < 16; i = i + 1) run_row('{{i[3:0], i[3:0]}, 2'h0, 5'h00, NC});
    $display("rop sweep done");
    // batch of three while memory refuses writes: the first word waits in the output stage, nothing completes
    stall <= 1'h1;
    for (i = 0; i < 3; i = i + 1) rbt_mem_model_inst.sys_mem[i] = mk(rows[0]);
    axi_wr(`RBT_CLIPX, NC);
    axi_rd(`RBT_DONECNT, c0);
    go(32'h3, 1'h0);
    repeat (100) @(posedge aclk);
    chk32({30'h0, busy, wr_valid}, 32'h3);
    axi_rd(`RBT_DONECNT, rv);
    chk32(rv, c0);
    stall <= 1'h0;
    while (busy !== 1'h0) @(posedge aclk);
    axi_rd(`RBT_DONECNT, rv);
    chk32(rv, c0 + 32'h3);
    $display("batch stall test done");
    print_verdict;
  end
endmodule // tb_top
